// [rtl/lsp_defines.svh]
// Purpose: constants of the loop alarm and setpoint profile block
// Assumes: 100 MHz pclk, APB word registers at index * 4
// Notes:   profile table memory sits at index LSP_IDX_TAB upward
//
// Function
// [R1] Compare per-sample change of measured value with the rate threshold word.
// [R2] Mode bit 14 enables the rate alarm on its own.
// [R3] Rate alarm has no hysteresis.
// [R4] Absolute and deviation alarms set as soon as threshold is passed.
// [R5] Hysteresis amount accepted from 1 to 200 hex.
// [R6] Software keeps hysteresis below the deviation threshold.
// [R7] Absolute and deviation alarms clear only hysteresis past the threshold.
// [R8] Alarm programming error unless LL<L<H<HH and yellow below red.
// [R9] Calculation error when output at a limit and target not reached.
// [R10] Software lets only one source write the target value.
// [R11] Ramp slope read as BCD 00.00 to 99.99 counts per second.
// [R12] Soak duration read as BCD 000.1 to 999.9 minutes.
// [R13] Table entries fetched when needed, never copied ahead.
// [R14] Profile of up to eight pairs, steps 1 to 16.
// [R15] Profile runs in run mode whatever the loop mode.
// [R16] Ramp direction from ramp start value against ramp end value.
// [R17] Table located by pointer word; loop block is 32 words.
// [R18] Four words per pair: end, slope, duration, band.
// [R19] Ramp starts after previous soak; first from start, at present target.
// [R20] Soak deviation flag when measured value leaves band in soak.
// [R21] Profile ends at a pair whose slope is zero.
// [R22] Start, hold, resume, jog commands; complete, deviation, step status.
// [R23] Command acts on 0-to-1 and is cleared by the device.
// [R24] Commands ignored unless generator enable bit 11 stays set.
// [R25] Flag word: bit 4 done, 5 deviation, 6 hold, 8-15 step.
// [R26] Hold freezes target, resume continues, jog ends the segment.
// [R27] Rate is absolute difference of successive samples against threshold.
`ifndef LSP_DEFINES_SVH
`define LSP_DEFINES_SVH

`define LSP_CLK_NS        10
`define LSP_TICK_MS       10
`define LSP_TICK_CYCLES   (`LSP_TICK_MS * 1000000 / `LSP_CLK_NS)
`define LSP_SOAK_UNIT_MS  6000
`define LSP_SOAK_TICKS    (`LSP_SOAK_UNIT_MS / `LSP_TICK_MS)
`define LSP_ACC_WRAP      14'h2710
`define LSP_LAST_PAIR     3'h7
`define LSP_LOOP_WORDS    32

`define LSP_IDX_MODE      10'h000
`define LSP_IDX_TARGET    10'h002
`define LSP_IDX_MEAS      10'h003
`define LSP_IDX_CTRL      10'h005
`define LSP_IDX_STAT      10'h006
`define LSP_IDX_LL        10'h008
`define LSP_IDX_L         10'h009
`define LSP_IDX_H         10'h00a
`define LSP_IDX_HH        10'h00b
`define LSP_IDX_HYST      10'h00c
`define LSP_IDX_YEL       10'h00f
`define LSP_IDX_RED       10'h010
`define LSP_IDX_RATE      10'h011
`define LSP_IDX_OUT_LO    10'h018
`define LSP_IDX_OUT_HI    10'h019
`define LSP_IDX_FLAGS     10'h01b
`define LSP_IDX_PTR       10'h01c
`define LSP_IDX_TAB       10'h100

`define LSP_MODE_GEN      11
`define LSP_MODE_ABS      12
`define LSP_MODE_DEV      13
`define LSP_MODE_RATE     14

`define LSP_CMD_START     0
`define LSP_CMD_HOLD      1
`define LSP_CMD_RESUME    2
`define LSP_CMD_JOG       3

`define LSP_HYST_MIN      16'h0001
`define LSP_HYST_MAX      16'h0200
`define LSP_HYST_RST      16'h0001
`define LSP_OUT_HI_RST    16'hffff

`endif

// [rtl/lsp_pkg.sv]
// Purpose: types of the loop alarm and setpoint profile block
// Assumes: nothing
// Notes:   state is one packed struct registered once
`default_nettype none
package lsp_pkg;

  typedef enum logic [2:0] {
    LSP_IDLE, LSP_NEXT, LSP_RAMP, LSP_SOAK, LSP_DONE
  } lsp_phase_t;

  typedef struct packed {
    logic [15:0] mode;
    logic [15:0] target;
    logic [15:0] meas;
    logic [15:0] prev;
    logic [15:0] ctrl;
    logic [15:0] out_lo;
    logic [15:0] out_hi;
    logic [15:0] thr_ll;
    logic [15:0] thr_l;
    logic [15:0] thr_h;
    logic [15:0] thr_hh;
    logic [15:0] hyst;
    logic [15:0] thr_yel;
    logic [15:0] thr_red;
    logic [15:0] thr_rate;
    logic [15:0] ptr;
    logic [3:0]  cmd;
    logic [6:0]  alm;
    logic        alm_err;
    logic        calc_err;
    logic        tab_err;
    lsp_phase_t  phase;
    logic        hold;
    logic        sdev;
    logic        dir_up;
    logic [2:0]  pair;
    logic [13:0] acc;
    logic [22:0] soak_cnt;
    logic [23:0] tick;
    logic [31:0] prdata;
    logic        run_s1;
    logic        run_s2;
  } lsp_state_t;

endpackage
`default_nettype wire

// [rtl/lsp_top.sv]
// Purpose: alarms and ramp/soak target generator of one control loop
// Assumes: sample_pulse comes from pclk logic; run_mode is a pin
// Notes:   zero-wait APB slave; profile table lives in local memory
//
// The APB register port is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
`include "lsp_defines.svh"

module lsp_top
  import lsp_pkg::*;
#(
  parameter int TICK_CYCLES = `LSP_TICK_CYCLES,
  parameter int TABLE_WORDS = 64
) (
  input  wire logic        pclk,         // APB clock
  input  wire logic        presetn,      // Async reset, active low
  input  wire logic        psel,         // APB select
  input  wire logic        penable,      // APB access phase
  input  wire logic        pwrite,       // APB direction
  input  wire logic [11:0] paddr,        // APB byte address
  input  wire logic [31:0] pwdata,       // APB write data
  output logic      [31:0] prdata,       // APB read data
  output logic             pready,       // APB ready
  output logic             pslverr,      // APB error, unmapped word
  input  wire logic        run_mode,     // Controller run mode pin
  input  wire logic        sample_pulse, // One loop sample period elapsed
  output logic      [15:0] target_value  // Present target value
);

  localparam int TW = $clog2(TABLE_WORDS);

  if (TICK_CYCLES < 1 || TICK_CYCLES >= (1 << 24)) begin : g_bad_tick
    $error("TICK_CYCLES out of range");
  end
  if (TABLE_WORDS < `LSP_LOOP_WORDS || TABLE_WORDS > 512) begin : g_bad_tab
    $error("TABLE_WORDS out of range");
  end

  lsp_state_t  s;
  lsp_state_t  n;
  logic [15:0] tab [TABLE_WORDS];
  logic [9:0]  idx;
  logic        setup;
  logic        wr;
  logic        hit;
  logic        tab_hit;
  logic [9:0]  tab_off;
  logic [31:0] rdata;
  logic        tick_now;
  logic [15:0] fbase;
  logic [15:0] fe_end;
  logic [15:0] fe_slope;
  logic [15:0] fe_dur;
  logic [15:0] fe_band;
  logic [13:0] slope_bin;
  logic [22:0] soak_load;
  logic [15:0] rate_now;
  logic [15:0] dev_now;
  logic [7:0]  step;
  logic        active;
  logic        ptr_bad;

  function automatic logic [13:0] lsp_bcd(input logic [15:0] b);
    lsp_bcd = 14'(b[15:12] * 1000 + b[11:8] * 100 + b[7:4] * 10 + b[3:0]);
  endfunction

  // Next state of a hysteresis alarm; above selects the upper-side sense
  function automatic logic lsp_hys(input logic cur, input logic above,
                                   input logic [15:0] v,
                                   input logic [15:0] t,
                                   input logic [15:0] h);
    logic [16:0] vh;
    logic [16:0] th;
    vh = {1'b0, v} + {1'b0, h};
    th = {1'b0, t} + {1'b0, h};
    if (above) begin
      lsp_hys = (v > t) ? 1'b1 : (vh <= {1'b0, t}) ? 1'b0 : cur;
    end else begin
      lsp_hys = (v < t) ? 1'b1 : ({1'b0, v} >= th) ? 1'b0 : cur;
    end
  endfunction

  assign idx     = paddr[11:2];
  assign setup   = psel && !penable;
  assign wr      = psel && penable && pwrite;
  assign tab_off = idx - `LSP_IDX_TAB;
  assign tab_hit = (idx >= `LSP_IDX_TAB) &&
                   (tab_off < 10'(TABLE_WORDS));
  assign pready  = 1'b1;
  assign pslverr = psel && penable && !hit;
  assign prdata  = s.prdata;
  assign target_value = s.target;

  // Entries are read straight from the table each time they are used
  assign fbase     = s.ptr + {11'h000, s.pair, 2'b00};               // R18
  assign fe_end    = tab[fbase[TW-1:0]];                             // R13
  assign fe_slope  = tab[TW'(fbase + 16'h0001)];
  assign fe_dur    = tab[TW'(fbase + 16'h0002)];
  assign fe_band   = tab[TW'(fbase + 16'h0003)];
  assign slope_bin = lsp_bcd(fe_slope);                              // R11
  assign soak_load = 23'(lsp_bcd(fe_dur) * `LSP_SOAK_TICKS);         // R12
  assign ptr_bad   = s.ptr > 16'(TABLE_WORDS - `LSP_LOOP_WORDS);     // R17
  assign tick_now  = s.tick == 24'(TICK_CYCLES - 1);
  assign rate_now  = (s.meas > s.prev) ? s.meas - s.prev
                                       : s.prev - s.meas;            // R27
  assign dev_now   = (s.meas > s.target) ? s.meas - s.target
                                         : s.target - s.meas;
  assign active    = s.phase == LSP_NEXT || s.phase == LSP_RAMP ||
                     s.phase == LSP_SOAK;
  assign step      = (s.phase == LSP_IDLE) ? 8'h00 :
                     (s.phase == LSP_SOAK || s.phase == LSP_DONE) ?
                     {4'h0, s.pair, 1'b0} + 8'h02 :
                     {4'h0, s.pair, 1'b0} + 8'h01;                   // R14

  always_comb begin
    hit   = 1'b1;
    rdata = 32'h0000_0000;
    if (tab_hit) begin
      rdata = {16'h0000, tab[tab_off[TW-1:0]]};
    end else begin
      case (idx)
        `LSP_IDX_MODE:   rdata = {16'h0000, s.mode};
        `LSP_IDX_TARGET: rdata = {16'h0000, s.target};
        `LSP_IDX_MEAS:   rdata = {16'h0000, s.meas};
        `LSP_IDX_CTRL:   rdata = {16'h0000, s.ctrl};
        `LSP_IDX_STAT:   rdata = {19'h0, s.tab_err, s.calc_err, s.alm_err,
                                  s.alm, 3'h0};
        `LSP_IDX_LL:     rdata = {16'h0000, s.thr_ll};
        `LSP_IDX_L:      rdata = {16'h0000, s.thr_l};
        `LSP_IDX_H:      rdata = {16'h0000, s.thr_h};
        `LSP_IDX_HH:     rdata = {16'h0000, s.thr_hh};
        `LSP_IDX_HYST:   rdata = {16'h0000, s.hyst};
        `LSP_IDX_YEL:    rdata = {16'h0000, s.thr_yel};
        `LSP_IDX_RED:    rdata = {16'h0000, s.thr_red};
        `LSP_IDX_RATE:   rdata = {16'h0000, s.thr_rate};
        `LSP_IDX_OUT_LO: rdata = {16'h0000, s.out_lo};
        `LSP_IDX_OUT_HI: rdata = {16'h0000, s.out_hi};
        `LSP_IDX_FLAGS:  rdata = {16'h0000, step, 1'b0, s.hold, s.sdev,
                                  s.phase == LSP_DONE, s.cmd};      // R25
        `LSP_IDX_PTR:    rdata = {16'h0000, s.ptr};
        default:         hit   = 1'b0;
      endcase
    end
  end

  always_comb begin
    n        = s;
    n.run_s1 = run_mode;
    n.run_s2 = s.run_s1;
    n.tick   = tick_now ? 24'h000000 : s.tick + 24'h000001;
    n.alm_err = !(s.thr_ll < s.thr_l && s.thr_l < s.thr_h &&
                  s.thr_h < s.thr_hh) || !(s.thr_yel < s.thr_red);  // R8

    if (sample_pulse && s.run_s2) begin
      n.prev   = s.meas;
      n.alm[6] = s.mode[`LSP_MODE_RATE] && rate_now > s.thr_rate;   // R1 R2 R3
      if (s.mode[`LSP_MODE_ABS]) begin
        n.alm[0] = lsp_hys(s.alm[0], 1'b0, s.meas, s.thr_ll, s.hyst); // R4 R7
        n.alm[1] = lsp_hys(s.alm[1], 1'b0, s.meas, s.thr_l, s.hyst);
        n.alm[2] = lsp_hys(s.alm[2], 1'b1, s.meas, s.thr_h, s.hyst);
        n.alm[3] = lsp_hys(s.alm[3], 1'b1, s.meas, s.thr_hh, s.hyst);
      end else begin
        n.alm[3:0] = 4'h0;
      end
      if (s.mode[`LSP_MODE_DEV]) begin
        n.alm[4] = lsp_hys(s.alm[4], 1'b1, dev_now, s.thr_yel, s.hyst);
        n.alm[5] = lsp_hys(s.alm[5], 1'b1, dev_now, s.thr_red, s.hyst);
      end else begin
        n.alm[5:4] = 2'h0;
      end
      n.calc_err = (s.ctrl == s.out_hi || s.ctrl == s.out_lo) &&
                   s.meas != s.target;                               // R9
    end

    // Loop mode plays no part: only run mode and the enable gate it
    if (s.run_s2 && s.mode[`LSP_MODE_GEN]) begin                     // R15
      if (!s.hold) begin
        case (s.phase)
          LSP_NEXT: begin
            if (fe_slope == 16'h0000) begin
              n.phase = LSP_DONE;                                    // R21
            end else begin
              n.phase  = LSP_RAMP;
              n.dir_up = fe_end > s.target;                          // R16
              n.acc    = 14'h0000;
            end
          end
          LSP_RAMP: begin
            if (s.target == fe_end) begin
              n.phase    = LSP_SOAK;
              n.soak_cnt = soak_load;
            end else if (tick_now) begin
              // Slope is below one count per tick, so one step at most
              if ({1'b0, s.acc} + {1'b0, slope_bin} >=
                  {1'b0, `LSP_ACC_WRAP}) begin
                n.acc    = s.acc + slope_bin - `LSP_ACC_WRAP;
                n.target = s.dir_up ? s.target + 16'h0001
                                    : s.target - 16'h0001;
              end else begin
                n.acc = s.acc + slope_bin;
              end
            end
          end
          LSP_SOAK: begin
            n.sdev = dev_now > fe_band;                              // R20
            if (s.soak_cnt == 23'h000000) begin
              n.sdev  = 1'b0;
              n.phase = (s.pair == `LSP_LAST_PAIR) ? LSP_DONE : LSP_NEXT;
              n.pair  = (s.pair == `LSP_LAST_PAIR) ? s.pair
                                                   : s.pair + 3'h1; // R19
            end else if (tick_now) begin
              n.soak_cnt = s.soak_cnt - 23'h000001;
            end
          end
          default: ;
        endcase
      end

      // A set bit here was written from zero, so it is the rising edge
      if (s.cmd[`LSP_CMD_START] && !active) begin                    // R22
        n.tab_err = ptr_bad;
        if (!ptr_bad) begin
          n.pair  = 3'h0;
          n.phase = LSP_NEXT;                                        // R19
          n.hold  = 1'b0;
          n.sdev  = 1'b0;
        end
      end
      if (s.cmd[`LSP_CMD_HOLD] && active) begin
        n.hold = 1'b1;                                               // R26
      end
      if (s.cmd[`LSP_CMD_RESUME]) begin
        n.hold = 1'b0;                                               // R26
      end
      if (s.cmd[`LSP_CMD_JOG] && s.phase == LSP_RAMP) begin
        n.phase    = LSP_SOAK;                                       // R26
        n.soak_cnt = soak_load;
      end else if (s.cmd[`LSP_CMD_JOG] && s.phase == LSP_SOAK) begin
        n.soak_cnt = 23'h000000;
        n.phase    = LSP_SOAK;
      end
      n.cmd = 4'h0;                                                  // R23
    end else if (s.run_s2) begin
      n.cmd = 4'h0;                                                  // R24
    end
    if (!s.mode[`LSP_MODE_GEN]) begin
      n.phase = LSP_IDLE;                                            // R24
      n.hold  = 1'b0;
    end

    if (setup) begin
      n.prdata = rdata;
    end
    // Software write lands last, so it wins over a same-cycle clear
    if (wr && !tab_hit) begin
      case (idx)
        `LSP_IDX_MODE:   n.mode     = pwdata[15:0];
        `LSP_IDX_TARGET: n.target   = pwdata[15:0];
        `LSP_IDX_MEAS:   n.meas     = pwdata[15:0];
        `LSP_IDX_CTRL:   n.ctrl     = pwdata[15:0];
        `LSP_IDX_LL:     n.thr_ll   = pwdata[15:0];
        `LSP_IDX_L:      n.thr_l    = pwdata[15:0];
        `LSP_IDX_H:      n.thr_h    = pwdata[15:0];
        `LSP_IDX_HH:     n.thr_hh   = pwdata[15:0];
        `LSP_IDX_YEL:    n.thr_yel  = pwdata[15:0];
        `LSP_IDX_RED:    n.thr_red  = pwdata[15:0];
        `LSP_IDX_RATE:   n.thr_rate = pwdata[15:0];
        `LSP_IDX_OUT_LO: n.out_lo   = pwdata[15:0];
        `LSP_IDX_OUT_HI: n.out_hi   = pwdata[15:0];
        `LSP_IDX_FLAGS:  n.cmd      = pwdata[3:0];
        `LSP_IDX_PTR:    n.ptr      = pwdata[15:0];
        `LSP_IDX_HYST: begin
          // Out-of-range amounts are clamped rather than refused
          n.hyst = (pwdata[15:0] < `LSP_HYST_MIN) ? `LSP_HYST_MIN :
                   (pwdata[15:0] > `LSP_HYST_MAX) ? `LSP_HYST_MAX :
                   pwdata[15:0];                                     // R5
        end
        default: ;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s        <= '0;
      s.hyst   <= `LSP_HYST_RST;
      s.out_hi <= `LSP_OUT_HI_RST;
      s.phase  <= LSP_IDLE;
    end else begin
      s <= n;
    end
  end

  // Table memory has no reset; software loads it before a start
  always_ff @(posedge pclk) begin
    if (wr && tab_hit) begin
      tab[tab_off[TW-1:0]] <= pwdata[15:0];
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  AST_RATE_OFF: assert property ( // R2
    sample_pulse && s.run_s2 && !s.mode[`LSP_MODE_RATE] |=> !s.alm[6])
    else $error("rate alarm set while disabled");

  AST_RATE_SET: assert property ( // R27
    sample_pulse && s.run_s2 && s.mode[`LSP_MODE_RATE] &&
    rate_now > s.thr_rate |=> s.alm[6])
    else $error("rate alarm missed");

  AST_ORDER_ERR: assert property ( // R8
    s.thr_yel >= s.thr_red |=> s.alm_err)
    else $error("programming error not flagged");

  AST_HH_SET: assert property ( // R4
    sample_pulse && s.run_s2 && s.mode[`LSP_MODE_ABS] &&
    s.meas > s.thr_hh |=> s.alm[3])
    else $error("high-high alarm not set");

  AST_HH_HOLD: assert property ( // R7
    sample_pulse && s.run_s2 && s.mode[`LSP_MODE_ABS] && s.alm[3] &&
    ({1'b0, s.meas} + {1'b0, s.hyst} > {1'b0, s.thr_hh}) |=> s.alm[3])
    else $error("high-high alarm cleared inside hysteresis");

  AST_HYST_RANGE: assert property ( // R5
    s.hyst >= `LSP_HYST_MIN && s.hyst <= `LSP_HYST_MAX)
    else $error("hysteresis out of range");

  AST_CMD_CLR: assert property ( // R23
    s.cmd != 4'h0 && s.run_s2 && !(wr && idx == `LSP_IDX_FLAGS)
    |=> s.cmd == 4'h0)
    else $error("command bit not cleared");

  AST_GEN_OFF: assert property ( // R24
    !s.mode[`LSP_MODE_GEN] |=> s.phase == LSP_IDLE ##1
    (s.phase == LSP_IDLE || s.mode[`LSP_MODE_GEN]))
    else $error("profile runs while generator disabled");

  AST_HOLD_FREEZE: assert property ( // R26
    s.hold && s.mode[`LSP_MODE_GEN] && !(wr && idx == `LSP_IDX_TARGET)
    |=> $stable(s.target))
    else $error("target moved during hold");

endmodule
`default_nettype wire

// [bench/lsp_tb.sv]
// Purpose: self-checking bench for the loop alarm and profile block
// Assumes: zero-wait APB slave, short tick parameter for the ramp clock
// Notes:   all register access goes through one APB task; one compare task
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic        pclk         = 1'b0;
  logic        presetn      = 1'b0;
  logic        psel         = 1'b0;
  logic        penable      = 1'b0;
  logic        pwrite       = 1'b0;
  logic [11:0] paddr        = 12'h000;
  logic [31:0] pwdata       = 32'h0000_0000;
  logic        run_mode     = 1'b0;
  logic        sample_pulse = 1'b0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [15:0] target_value;
  logic [15:0] q;
  logic [15:0] a;
  logic        err;
  int          fail_count   = 0;
  int          compares     = 0;
  int          cyc          = 0;

  always #5 pclk = ~pclk;

  lsp_top #(.TICK_CYCLES(4), .TABLE_WORDS(64)) lsp_top_inst (
    .pclk         (pclk),
    .presetn      (presetn),
    .psel         (psel),
    .penable      (penable),
    .pwrite       (pwrite),
    .paddr        (paddr),
    .pwdata       (pwdata),
    .prdata       (prdata),
    .pready       (pready),
    .pslverr      (pslverr),
    .run_mode     (run_mode),
    .sample_pulse (sample_pulse),
    .target_value (target_value)
  );

  task automatic print_verdict;
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // Guards against a hang in any wait below
  always @(posedge pclk) begin
    cyc = cyc + 1;
    if (cyc == 60000) begin
      fail_count++;
      print_verdict();
    end
  end

  task automatic chk(input string nm, input logic [15:0] exp,
                     input logic [15:0] got);
    compares++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // Request held until pready is sampled high at a rising edge
  task automatic apb(input logic w, input logic [9:0] idx,
                     input logic [15:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= {idx, 2'b00};
    pwdata  <= {16'h0000, d};
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    q = prdata[15:0];
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [9:0] idx, input logic [15:0] d);
    apb(1'b1, idx, d);
  endtask

  task automatic rd(input logic [9:0] idx);
    apb(1'b0, idx, 16'h0000);
  endtask

  task automatic stat_bit(input string nm, input int b, input logic e);
    rd(10'h006);
    chk(nm, {15'h0000, e}, {15'h0000, q[b]});
  endtask

  // New measured value followed by one loop sample
  task automatic sample(input logic [15:0] m);
    wr(10'h003, m);
    @(posedge pclk);
    sample_pulse <= 1'b1;
    @(posedge pclk);
    sample_pulse <= 1'b0;
    repeat (2) @(posedge pclk);
  endtask

  initial begin
    repeat (20) @(posedge pclk);
    presetn  <= 1'b1;
    run_mode <= 1'b1;
    repeat (3) @(posedge pclk);
    rd(10'h00c); chk("hyst_reset", 16'h0001, q);
    rd(10'h019); chk("out_hi_reset", 16'hffff, q);
    chk("target_reset", 16'h0000, target_value);
    rd(10'h03f); chk("unmapped_err", 16'h0001, {15'h0000, err});
    wr(10'h00c, 16'h0000); rd(10'h00c); chk("hyst_low", 16'h0001, q);
    wr(10'h00c, 16'h0300); rd(10'h00c); chk("hyst_high", 16'h0200, q);
    wr(10'h008, 16'h000a); wr(10'h009, 16'h0014);
    wr(10'h00a, 16'h001e); wr(10'h00b, 16'h0028);
    wr(10'h00f, 16'h0005); wr(10'h010, 16'h0009);
    wr(10'h00c, 16'h0004);
    stat_bit("prog_ok", 10, 1'b0);
    wr(10'h009, 16'h001e); stat_bit("prog_l_eq_h", 10, 1'b1);
    wr(10'h009, 16'h0014); wr(10'h010, 16'h0005);
    stat_bit("prog_yel_eq_red", 10, 1'b1);
    wr(10'h010, 16'h0009); stat_bit("prog_fixed", 10, 1'b0);
    // Absolute group and rate alarm on
    wr(10'h000, 16'h5000); wr(10'h011, 16'h0005);
    sample(16'h0019); sample(16'h001f);
    stat_bit("high_set", 5, 1'b1);
    stat_bit("rate_set", 9, 1'b1);
    sample(16'h001b); stat_bit("high_held", 5, 1'b1);
    stat_bit("rate_clear", 9, 1'b0);
    sample(16'h001a); stat_bit("high_clear", 5, 1'b0);
    sample(16'h001f); stat_bit("rate_at_thr", 9, 1'b0);
    wr(10'h000, 16'h1000); sample(16'h0014);
    stat_bit("rate_off", 9, 1'b0);
    sample(16'h002a); stat_bit("hh_set", 6, 1'b1);
    sample(16'h0025); stat_bit("hh_held", 6, 1'b1);
    // Low output limit off zero so only the upper limit can match
    wr(10'h018, 16'h0001);
    wr(10'h005, 16'hffff); sample(16'h0014);
    stat_bit("calc_err", 11, 1'b1);
    wr(10'h002, 16'h0014); sample(16'h0014);
    stat_bit("calc_ok", 11, 1'b0);
    wr(10'h005, 16'h0000);
    // Deviation group alone, around the target of 0x14
    wr(10'h000, 16'h2000); sample(16'h001a);
    stat_bit("yel_set", 7, 1'b1);
    stat_bit("calc_free", 11, 1'b0);
    sample(16'h0017); stat_bit("yel_held", 7, 1'b1);
    // Profile: table too close to the end of memory
    wr(10'h01c, 16'h0021); wr(10'h000, 16'h0800); wr(10'h01b, 16'h0001);
    repeat (4) @(posedge pclk);
    stat_bit("ptr_err", 12, 1'b1);
    wr(10'h100, 16'h1000); wr(10'h101, 16'h9999);
    wr(10'h102, 16'h0001); wr(10'h103, 16'h0005);
    wr(10'h104, 16'h0000); wr(10'h105, 16'h9999);
    wr(10'h01c, 16'h0000); wr(10'h002, 16'h0800);
    wr(10'h01b, 16'h0001);
    repeat (4) @(posedge pclk);
    rd(10'h01b); chk("flags_start", 16'h0100, q);
    stat_bit("ptr_ok", 12, 1'b0);
    repeat (40) @(posedge pclk);
    chk("ramp_up", 16'h0001, {15'h0000, target_value > 16'h0800});
    wr(10'h01b, 16'h0002);
    repeat (4) @(posedge pclk);
    a = target_value;
    rd(10'h01b); chk("in_hold", 16'h0001, {15'h0000, q[6]});
    repeat (40) @(posedge pclk);
    chk("frozen", a, target_value);
    wr(10'h01b, 16'h0004);
    repeat (40) @(posedge pclk);
    chk("resumed", 16'h0001, {15'h0000, target_value > a});
    // Later pair edited after start: table is read when needed
    wr(10'h105, 16'h0000);
    wr(10'h01b, 16'h0008);
    repeat (4) @(posedge pclk);
    rd(10'h01b); chk("jog_step", 16'h0002, {8'h00, q[15:8]});
    sample(16'h0000);
    rd(10'h01b); chk("soak_dev", 16'h0001, {15'h0000, q[5]});
    wr(10'h01b, 16'h0008);
    repeat (6) @(posedge pclk);
    rd(10'h01b); chk("complete", 16'h0001, {15'h0000, q[4]});
    // Generator disabled: start is dropped and cleared
    wr(10'h000, 16'h0000); wr(10'h01b, 16'h0001);
    repeat (4) @(posedge pclk);
    rd(10'h01b); chk("no_gen", 16'h0000, q & 16'hff0f);
    print_verdict();
  end
endmodule
`default_nettype wire
